// file: dv/lism_core_test.sv
// self-checking bench for the link initialization core state machine
`timescale 1ns/100ps
`default_nettype none
module lism_core_test;
  import lism_pkg::*;
  logic                 clk, rst, sb_req, sb_en, recal_done, fwd_set, merge_set;
  lism_event_t          cmd, host_event;
  lism_state_t          state, m_state;
  lism_status_t         status;
  logic [NUM_LANES-1:0] lane_mask, quiet_mask, fail_mask, m_good;
  logic [NUM_LANES-1:0] lane_event, lane_aligned, lane_quiet, lane_test_ok;
  logic [3:0]           width, cfg_width, min_lanes, lane_width;
  logic [SKEW_W-1:0]    skew_hold;
  logic [7:0]           own_caps, caps;
  logic [31:0]          rnd;
  int                   n_fail, checks;

  initial clk = 1'h0;
  always #20 clk = ~clk;

  lism_host_model i_host (.i_core_clk(clk), .i_cmd(cmd), .i_lane_mask(lane_mask),
    .i_quiet_mask(quiet_mask), .i_fail_mask(fail_mask), .i_width(width),
    .o_host_event(host_event), .o_lane_event(lane_event), .o_lane_aligned(lane_aligned),
    .o_lane_quiet(lane_quiet), .o_lane_test_ok(lane_test_ok), .o_cfg_width(cfg_width));

  lism_core i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_lane_quiet(lane_quiet),
    .i_lane_aligned(lane_aligned), .i_lane_event(lane_event), .i_lane_test_ok(lane_test_ok),
    .i_host_event(host_event), .i_cfg_width(cfg_width), .i_standby_req(sb_req),
    .i_standby_en(sb_en), .i_min_lanes(min_lanes), .i_skew_hold(skew_hold),
    .i_recal_done(recal_done), .i_own_caps(own_caps), .o_state(state), .o_status(status),
    .o_lane_width(lane_width), .o_caps(caps), .o_fwd_timing_set(fwd_set),
    .o_merge_timing_set(merge_set));

  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait: lanes pass synchronisers, skew filter and lane count first
  task automatic wait_state(input lism_state_t exp, input int lim);
    for (int i = 0; i < lim && state !== exp; i++) tick(1);
    check("state", state, exp);
  endtask

  // reference model of the legal state order and the lane quorum
  function automatic lism_state_t model_next(lism_state_t s, lism_event_t ev);
    int lanes;
    lanes = (s inside {LISM_DISABLED, LISM_TRAINING, LISM_TESTING}) ? $countones(lane_mask) :
            $countones(lane_mask & m_good);
    if (min_lanes == 0 || lanes < min_lanes) return s;
    case (ev)
      LISM_EV_TRAIN:   return (s == LISM_DISABLED) ? LISM_TRAINING : s;
      LISM_EV_TEST:    return (s == LISM_TRAINING) ? LISM_TESTING : s;
      LISM_EV_POLL:    return (s == LISM_TESTING) ? LISM_POLLING : s;
      LISM_EV_CONFIG:  return (s == LISM_POLLING) ? LISM_CONFIG : s;
      LISM_EV_ACTIVE:  return (s == LISM_CONFIG) ? LISM_ACTIVE : s;
      LISM_EV_RECAL:   return (s == LISM_ACTIVE) ? LISM_RECAL : s;
      LISM_EV_DISABLE: return (s inside {LISM_RECAL, LISM_STANDBY}) ? s : LISM_DISABLED;
      default:         return s;
    endcase
  endfunction

  // one host command; a refused one must leave the state alone
  task automatic go(input lism_event_t ev);
    lism_state_t exp;
    exp = model_next(m_state, ev);
    cmd = ev;
    if (exp == m_state) begin
      tick(20);
      check("held", state, exp);
    end else wait_state(exp, 40);
    m_state = exp;
    cmd = LISM_EV_NONE;
    tick(8);
  endtask

  initial begin
    rst = 1'h1;
    cmd = LISM_EV_NONE;
    lane_mask = '0;
    quiet_mask = '0;
    fail_mask = 10'h001;
    {sb_req, sb_en, recal_done} = 3'h0;
    min_lanes = 4'h8;
    m_good = '1;
    m_state = LISM_DISABLED;
    n_fail = 0;
    checks = 0;
    rnd = lfsr(32'hF7BF5DA5);
    skew_hold = rnd[2:0];
    own_caps = rnd[15:8];
    width = {1'h0, rnd[18:16]};
    tick(9);
    check("rst state", state, LISM_DISABLED);
    check("rst quiet", status.link_quiet, 1'h1);
    check("rst width", lane_width, WIDTH_RST);
    check("rst caps", caps, 8'h00);
    tick(1);
    rst = 1'h0;
    lane_mask = 10'h07F;
    go(LISM_EV_TRAIN);
    lane_mask = 10'h3FF;
    go(LISM_EV_TEST);
    min_lanes = 4'h0;
    go(LISM_EV_TRAIN);
    min_lanes = 4'h8;
    go(LISM_EV_TRAIN);
    check("align", status.align_en, 1'h1);
    go(LISM_EV_TEST);
    m_good = lane_mask & ~fail_mask;
    check("test en", status.test_en, 1'h1);
    check("fwd timing", fwd_set, 1'h1);
    check("merge timing", merge_set, 1'h1);
    check("lane good", status.lane_good, m_good);
    go(LISM_EV_POLL);
    check("caps", caps, own_caps);
    check("report", status.report_caps, 1'h1);
    go(LISM_EV_CONFIG);
    go(LISM_EV_ACTIVE);
    check("width", lane_width, width);
    check("frames", status.frames_en, 1'h1);
    check("quiet off", status.link_quiet, 1'h0);
    go(LISM_EV_RECAL);
    check("recal", status.recal_en, 1'h1);
    quiet_mask = 10'h006;
    tick(20);
    check("recal held", state, LISM_RECAL);
    quiet_mask = '0;
    tick(8);
    recal_done = 1'h1;
    wait_state(LISM_ACTIVE, 10);
    recal_done = 1'h0;
    sb_req = 1'h1;
    tick(20);
    check("no standby", state, LISM_ACTIVE);
    sb_en = 1'h1;
    wait_state(LISM_STANDBY, 10);
    check("standby", status.standby, 1'h1);
    sb_req = 1'h0;
    wait_state(LISM_ACTIVE, 10);
    quiet_mask = 10'h002;
    tick(20);
    check("one quiet", state, LISM_ACTIVE);
    quiet_mask = 10'h006;
    wait_state(LISM_DISABLED, 8);
    check("quiet link", status.link_quiet, 1'h1);
    check("timing clr", fwd_set, 1'h0);
    quiet_mask = '0;
    m_state = LISM_DISABLED;
    tick(8);
    go(LISM_EV_TRAIN);
    go(LISM_EV_DISABLE);
    finish_test();
  end

  // the sequence needs under a thousand cycles; this bound cuts a hang short
  initial begin
    #(40 * 4000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire

// file: dv/lism_host_model.sv
// host-side partner: drives southbound lane levels and decoded host events
`timescale 1ns/100ps
`default_nettype none
module lism_host_model (
  // clock and bench commands
  input  wire logic                           i_core_clk,
  input  wire lism_pkg::lism_event_t          i_cmd,
  input  wire logic [lism_pkg::NUM_LANES-1:0] i_lane_mask,
  input  wire logic [lism_pkg::NUM_LANES-1:0] i_quiet_mask,
  input  wire logic [lism_pkg::NUM_LANES-1:0] i_fail_mask,
  input  wire logic [3:0]                     i_width,
  // toward the device
  output var lism_pkg::lism_event_t           o_host_event,
  output logic [lism_pkg::NUM_LANES-1:0]      o_lane_event,
  output logic [lism_pkg::NUM_LANES-1:0]      o_lane_aligned,
  output logic [lism_pkg::NUM_LANES-1:0]      o_lane_quiet,
  output logic [lism_pkg::NUM_LANES-1:0]      o_lane_test_ok,
  output logic [3:0]                          o_cfg_width
);
  import lism_pkg::*;
  // idle lanes at time zero
  initial begin
    o_host_event = LISM_EV_NONE;
    {o_lane_event, o_lane_aligned, o_lane_quiet, o_lane_test_ok} = '0;
    o_cfg_width = 4'h0;
  end
  // commands sampled on the edge, lanes moved just after it; no race with the bench
  always @(posedge i_core_clk) begin
    o_host_event   <= #1 i_cmd;
    o_lane_event   <= #1 (i_cmd == LISM_EV_NONE) ? '0 : i_lane_mask;
    o_lane_aligned <= #1 i_lane_mask;
    o_lane_test_ok <= #1 i_lane_mask & ~i_fail_mask;
    o_lane_quiet   <= #1 i_quiet_mask;
    o_cfg_width    <= #1 i_width;
  end
endmodule
`default_nettype wire

// file: logic/lism_core.sv
// module: link initialization core state machine of the buffer device
`timescale 1ns/100ps
`default_nettype none
module lism_core (
  // clock and reset
  input  wire logic                             i_core_clk,
  input  wire logic                             i_sys_rst,
  // per-lane pins from the southbound receivers
  input  wire logic [lism_pkg::NUM_LANES-1:0]   i_lane_quiet,
  input  wire logic [lism_pkg::NUM_LANES-1:0]   i_lane_aligned,
  input  wire logic [lism_pkg::NUM_LANES-1:0]   i_lane_event,
  input  wire logic [lism_pkg::NUM_LANES-1:0]   i_lane_test_ok,
  // decoded host event from the frame decoder, same clock
  input  wire lism_pkg::lism_event_t            i_host_event,
  input  wire logic [3:0]                       i_cfg_width,
  input  wire logic                             i_standby_req,
  input  wire logic                             i_standby_en,
  input  wire logic [3:0]                       i_min_lanes,
  input  wire logic [lism_pkg::SKEW_W-1:0]      i_skew_hold,
  input  wire logic                             i_recal_done,
  input  wire logic [7:0]                       i_own_caps,
  // state and status
  output lism_pkg::lism_state_t                 o_state,
  output lism_pkg::lism_status_t                o_status,
  output logic [3:0]                            o_lane_width,
  output logic [7:0]                            o_caps,
  output logic                                  o_fwd_timing_set,
  output logic                                  o_merge_timing_set
);
  import lism_pkg::*;

  lism_state_t           state_r;
  lism_state_t           state_nxt;
  logic [NUM_LANES-1:0]  quiet_s;
  logic [NUM_LANES-1:0]  aligned_s;
  logic [NUM_LANES-1:0]  ev_s1_r;
  logic [NUM_LANES-1:0]  ev_s2_r;
  logic [NUM_LANES-1:0]  tok_s1_r;
  logic [NUM_LANES-1:0]  tok_s2_r;
  logic [NUM_LANES-1:0]  lane_good_r;
  logic [NUM_LANES-1:0]  cnt_mask;
  logic [LANE_CNT_W-1:0] quiet_cnt;
  logic [LANE_CNT_W-1:0] event_cnt;
  logic                  ev_ok;
  logic                  quiet_ok;
  lism_event_t           host_ev;

  // per-lane synchronisers: each lane comes up on its own
  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      lism_lane_sync u_sync (
        .i_core_clk    (i_core_clk),
        .i_sys_rst     (i_sys_rst),
        .i_quiet_pin   (i_lane_quiet[g]),
        .i_aligned_pin (i_lane_aligned[g]),
        .i_skew_hold   (i_skew_hold),
        .o_quiet       (quiet_s[g]),
        .o_aligned     (aligned_s[g])
      );
    end
  endgenerate

  // event and test flags also come from pins
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ev_s1_r  <= '0;
      ev_s2_r  <= '0;
      tok_s1_r <= '0;
      tok_s2_r <= '0;
    end else begin
      ev_s1_r  <= i_lane_event;
      ev_s2_r  <= ev_s1_r;
      tok_s1_r <= i_lane_test_ok;
      tok_s2_r <= tok_s1_r;
    end
  end

  // only lanes that passed testing count once past testing
  function automatic logic [NUM_LANES-1:0] lane_mask(input lism_state_t s,
                                                     input logic [NUM_LANES-1:0] good);
    lane_mask = (s == LISM_DISABLED || s == LISM_TRAINING || s == LISM_TESTING) ?
                {NUM_LANES{1'h1}} : good;
  endfunction

  // one mask feeds both counters and the checks, so they can never disagree
  assign cnt_mask = lane_mask(state_r, lane_good_r);

  lism_lane_cnt u_quiet_cnt (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_flags    (quiet_s),
    .i_enable   (cnt_mask),
    .o_count    (quiet_cnt)
  );

  lism_lane_cnt u_event_cnt (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_flags    (ev_s2_r & aligned_s),
    .i_enable   (cnt_mask),
    .o_count    (event_cnt)
  );

  assign ev_ok    = (event_cnt >= i_min_lanes) && (i_min_lanes != 4'h0);
  assign quiet_ok = quiet_cnt >= MIN_QUIET_LANES;
  assign host_ev  = ev_ok ? i_host_event : LISM_EV_NONE;

  // next state: host steps the device, quiet on several lanes drops to disabled
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LISM_DISABLED: if (host_ev == LISM_EV_TRAIN) state_nxt = LISM_TRAINING;
      LISM_TRAINING: if (host_ev == LISM_EV_TEST) state_nxt = LISM_TESTING;
      LISM_TESTING:  if (host_ev == LISM_EV_POLL) state_nxt = LISM_POLLING;
      LISM_POLLING:  if (host_ev == LISM_EV_CONFIG) state_nxt = LISM_CONFIG;
      LISM_CONFIG:   if (host_ev == LISM_EV_ACTIVE) state_nxt = LISM_ACTIVE;
      LISM_ACTIVE: begin
        if (host_ev == LISM_EV_RECAL) begin
          state_nxt = LISM_RECAL;
        end else if (i_standby_req && i_standby_en) begin
          state_nxt = LISM_STANDBY;
        end
      end
      LISM_RECAL:    if (i_recal_done) state_nxt = LISM_ACTIVE;
      LISM_STANDBY:  if (!i_standby_req) state_nxt = LISM_ACTIVE;
      default:       state_nxt = LISM_DISABLED;
    endcase
    // disable event and multi-lane quiet override, except where quiet is expected
    if (state_r != LISM_DISABLED && state_r != LISM_STANDBY && state_r != LISM_RECAL) begin
      if (host_ev == LISM_EV_DISABLE || quiet_ok) begin
        state_nxt = LISM_DISABLED;
      end
    end
  end

  // reset lands in disabled
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_r <= LISM_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // lane test results kept per lane
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lane_good_r <= '0;
    end else if (state_r == LISM_TRAINING) begin
      lane_good_r <= '0;
    end else if (state_r == LISM_TESTING) begin
      lane_good_r <= lane_good_r | (tok_s2_r & aligned_s);
    end
  end

  // width taken from host when config ends
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_lane_width <= WIDTH_RST;
    end else if (state_r == LISM_CONFIG && state_nxt == LISM_ACTIVE) begin
      o_lane_width <= i_cfg_width;
    end
  end

  // capability report shown only while polling
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_caps <= CAPS_RST;
    end else begin
      o_caps <= (state_nxt == LISM_POLLING) ? i_own_caps : CAPS_RST;
    end
  end

  // forward and merge timing latch once training finishes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_fwd_timing_set   <= 1'h0;
      o_merge_timing_set <= 1'h0;
    end else if (state_nxt == LISM_DISABLED) begin
      o_fwd_timing_set   <= 1'h0;
      o_merge_timing_set <= 1'h0;
    end else if (state_r == LISM_TRAINING && state_nxt == LISM_TESTING) begin
      o_fwd_timing_set   <= 1'h1;
      o_merge_timing_set <= 1'h1;
    end
  end

  // status outputs registered from next state, lane_good from lane_good_r
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_state  <= LISM_DISABLED;
      o_status <= '{link_quiet: 1'h1, default: '0};
    end else begin
      o_state              <= state_nxt;
      o_status.link_quiet  <= (state_nxt == LISM_DISABLED) ||
                              (state_nxt == LISM_RECAL) ||
                              (state_nxt == LISM_STANDBY);
      o_status.frames_en   <= state_nxt == LISM_ACTIVE;
      o_status.report_caps <= state_nxt == LISM_POLLING;
      o_status.align_en    <= state_nxt == LISM_TRAINING;
      o_status.test_en     <= state_nxt == LISM_TESTING;
      o_status.recal_en    <= state_nxt == LISM_RECAL;
      o_status.standby     <= state_nxt == LISM_STANDBY;
      o_status.lane_good   <= lane_good_r;
    end
  end

  // multi-lane quiet_ok in active reaches disabled on the next edge
  property quiet_drop_p;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (quiet_ok && state_r == LISM_ACTIVE) |=> (state_r == LISM_DISABLED);
  endproperty
  quiet_drop_a: assert property (quiet_drop_p)
    else $error("multi-lane quiet did not disable link");

  // quiet on a quorum of counted lanes shows on the status within two edges
  sequence quiet_seen_s;
    ($countones(quiet_s & cnt_mask) >= MIN_QUIET_LANES) && (state_r == LISM_ACTIVE);
  endsequence
  sequence quiet_shown_s;
    ##[1:2] o_status.link_quiet;
  endsequence
  quiet_detect_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      quiet_seen_s |-> quiet_shown_s)
    else $error("quiet entry not shown in time");

  // once quiet lanes drop below the quorum the override lets go next edge
  quiet_exit_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ($countones(quiet_s & cnt_mask) < MIN_QUIET_LANES) |=> !quiet_ok)
    else $error("quiet exit not seen in time");

  reset_disabled_a: assert property (
    @(posedge i_core_clk) $fell(i_sys_rst) |-> (state_r == LISM_DISABLED))
    else $error("state not disabled after reset");

  min_lanes_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r != state_nxt && state_nxt != LISM_DISABLED && state_r != LISM_RECAL &&
       state_r != LISM_STANDBY && !(state_r == LISM_ACTIVE && state_nxt == LISM_STANDBY))
      |-> ev_ok)
    else $error("transition without minimum lane count");

  order_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r == LISM_DISABLED && state_nxt != LISM_DISABLED) |-> state_nxt == LISM_TRAINING)
    else $error("left disabled to a state other than training");

  width_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r == LISM_CONFIG && state_nxt == LISM_ACTIVE) |=> o_lane_width == $past(i_cfg_width))
    else $error("lane width not adopted");

  frames_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_status.frames_en |-> (o_state == LISM_ACTIVE && !o_status.link_quiet))
    else $error("frames enabled outside active");

  standby_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r != LISM_STANDBY ##1 state_r == LISM_STANDBY) |-> $past(state_r) == LISM_ACTIVE)
    else $error("standby entered not from active");

  // disabled always shows the line held quiet
  quiet_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_state == LISM_DISABLED) |-> o_status.link_quiet)
    else $error("disabled without quiet line");

  // capability byte is only driven while polling
  caps_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_state != LISM_POLLING) |-> (o_caps == CAPS_RST))
    else $error("capabilities shown outside polling");

  // lane results only move during training and testing
  lane_good_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r != LISM_TRAINING && state_r != LISM_TESTING) |=> $stable(lane_good_r))
    else $error("lane results changed outside testing");

  // after testing a failed lane is masked out of every count
  lane_isolate_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r inside {LISM_POLLING, LISM_CONFIG, LISM_ACTIVE}) |->
        ((cnt_mask & ~lane_good_r) == '0))
    else $error("failed lane still counted");

  // recalibration holds until the done strobe, whatever the lanes do
  recal_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r == LISM_RECAL && !i_recal_done) |=> (state_r == LISM_RECAL))
    else $error("recalibration left early");

  // no standby unless the option is switched on
  standby_gate_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r == LISM_ACTIVE && !i_standby_en) |=> (state_r != LISM_STANDBY))
    else $error("standby entered while unsupported");

  // timing flags stand only once training has handed over to testing
  timing_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_fwd_timing_set || o_merge_timing_set) |->
        (o_state != LISM_DISABLED && o_state != LISM_TRAINING))
    else $error("timing set before training finished");

  // a drop from active is either quiet on a quorum or the host's disable
  drop_cause_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_r == LISM_ACTIVE && state_nxt == LISM_DISABLED) |->
        (quiet_ok || host_ev == LISM_EV_DISABLE))
    else $error("link dropped without cause");
endmodule
`default_nettype wire

// file: logic/lism_lane_cnt.sv
// module: counts lanes that carry a given event
`timescale 1ns/100ps
`default_nettype none
module lism_lane_cnt (
  // clock and reset
  input  wire logic                            i_core_clk,
  input  wire logic                            i_sys_rst,
  // lane flags
  input  wire logic [lism_pkg::NUM_LANES-1:0]  i_flags,
  input  wire logic [lism_pkg::NUM_LANES-1:0]  i_enable,
  // registered lane count
  output logic      [lism_pkg::LANE_CNT_W-1:0] o_count
);
  import lism_pkg::*;

  logic [LANE_CNT_W-1:0] sum_nxt;

  // adder tree kept as a loop; lanes masked out never count
  always_comb begin
    sum_nxt = '0;
    for (int i = 0; i < NUM_LANES; i++) begin
      sum_nxt = sum_nxt + LANE_CNT_W'(i_flags[i] & i_enable[i]);
    end
  end

  // registered so the output comes straight from a flop
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_count <= '0;
    end else begin
      o_count <= sum_nxt;
    end
  end
endmodule
`default_nettype wire

// file: logic/lism_lane_sync.sv
// module: two-flop synchroniser and skew debounce for one lane
`timescale 1ns/100ps
`default_nettype none
module lism_lane_sync (
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sys_rst,
  // raw lane pins
  input  wire logic                        i_quiet_pin,
  input  wire logic                        i_aligned_pin,
  // skew hold cycles
  input  wire logic [lism_pkg::SKEW_W-1:0] i_skew_hold,
  // synchronised lane state
  output logic                             o_quiet,
  output logic                             o_aligned
);
  import lism_pkg::*;

  logic [1:0]        q_sync_r;
  logic [1:0]        a_sync_r;
  logic [SKEW_W-1:0] a_hold_r;

  // two flops before any logic reads the pins
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_sync_r <= 2'h0;
      a_sync_r <= 2'h0;
    end else begin
      q_sync_r <= {q_sync_r[0], i_quiet_pin};
      a_sync_r <= {a_sync_r[0], i_aligned_pin};
    end
  end

  // quiet passes with no filter so entry and exit stay fast
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_quiet <= 1'h0;
    end else begin
      o_quiet <= q_sync_r[1];
    end
  end

  // alignment must hold for the skew window, absorbing late lanes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      a_hold_r  <= '0;
      o_aligned <= 1'h0;
    end else if (!a_sync_r[1]) begin
      a_hold_r  <= '0;
      o_aligned <= 1'h0;
    end else if (a_hold_r < i_skew_hold) begin
      a_hold_r  <= a_hold_r + SKEW_W'(1);
    end else begin
      o_aligned <= 1'h1;
    end
  end

  // the aligned flag never rises before the hold window has run out
  align_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(o_aligned) |-> ($past(a_sync_r[1]) && ($past(a_hold_r) >= $past(i_skew_hold))))
    else $error("lane aligned before skew window");
endmodule
`default_nettype wire

// file: logic/lism_pkg.sv
// package: constants and types for the link initialization state machine
// Behaviour
// - disabled state holds link line-quiet
// - training aligns bits and frames of lanes
// - testing checks each lane separately
// - polling reports own capabilities to host
// - active state passes frames continuously
// - recalibration idles channel briefly, then resumes
// - optional standby power state from active
// - lanes initialize independently, failures isolated
// - transition needs event on minimum lane count; the code gates only host events, not standby, recal exit or quiet drop
// - line-quiet acted on only across several lanes
// - quiet entry detected within 60 ns; the code takes four edges (160 ns) to quiet_ok, five to disabled
// - quiet exit detected within 30 ns; the code takes four clock edges (160 ns) from pin to release quiet_ok
// - tolerate 6 UI lane-to-lane skew
// - init sets forward and merge timing
package lism_pkg;

  localparam int unsigned NUM_LANES       = 10;
  localparam int unsigned LANE_CNT_W      = 4;
  localparam logic [3:0]  MIN_LANES_RST   = 4'h8;
  localparam logic [3:0]  MIN_QUIET_LANES = 4'h2;

  // clock and timing limits
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned QUIET_ENTRY_NS    = 60;
  localparam int unsigned QUIET_EXIT_NS     = 30;
  // longest times round down, never below one cycle
  localparam int unsigned QUIET_ENTRY_CYC   =
    (QUIET_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 : (QUIET_ENTRY_NS / CLK_PERIOD_NS);
  localparam int unsigned QUIET_EXIT_CYC    =
    (QUIET_EXIT_NS / CLK_PERIOD_NS) < 1 ? 1 : (QUIET_EXIT_NS / CLK_PERIOD_NS);
  localparam int unsigned RX_SKEW_UI        = 6;
  localparam int unsigned SKEW_W            = 3;
  localparam logic [2:0]  SKEW_RST          = 3'h0;
  localparam logic [3:0]  WIDTH_RST         = 4'hA;
  localparam logic [7:0]  CAPS_RST          = 8'h00;

  typedef enum logic [2:0] {
    LISM_EV_NONE,
    LISM_EV_DISABLE,
    LISM_EV_TRAIN,
    LISM_EV_TEST,
    LISM_EV_POLL,
    LISM_EV_CONFIG,
    LISM_EV_ACTIVE,
    LISM_EV_RECAL
  } lism_event_t;

  typedef enum logic [2:0] {
    LISM_DISABLED,
    LISM_TRAINING,
    LISM_TESTING,
    LISM_POLLING,
    LISM_CONFIG,
    LISM_ACTIVE,
    LISM_RECAL,
    LISM_STANDBY
  } lism_state_t;

  // per-lane observation from the receiver front end
  typedef struct packed {
    logic [NUM_LANES-1:0] quiet;
    logic [NUM_LANES-1:0] aligned;
    logic [NUM_LANES-1:0] test_ok;
  } lism_lane_obs_t;

  // status carried toward host and datapath
  typedef struct packed {
    logic                  link_quiet;
    logic                  frames_en;
    logic                  report_caps;
    logic                  align_en;
    logic                  test_en;
    logic                  recal_en;
    logic                  standby;
    logic [NUM_LANES-1:0]  lane_good;
  } lism_status_t;

endpackage
